// ### pkg/swie_map.vh
// Constants for the switch interrupt-enable and low-power configuration registers.
// ==========================================================================
// Notes on behaviour
// - A cleared enable bit blocks interrupts from that input's state changes.
// - A set enable bit raises an interrupt on each state change of that input.
// - Host may rewrite enable registers any time; writes apply at once.
// - Implemented enable bits reset to one; bits without channel reset to zero.
// - Reply bit 23 shows the live global fault indicator.
// - Reply bit 22 shows the global interrupt-event flag.
// - In low power, a nonzero wake select wakes and interrupts on expiry.
// - Wake select code zero disables the timed wake entirely.
// - Wake select sits in bits 7 to 4, resets zero, coded periods.
// - Low-power polling events are spaced by the selected polling interval.
// - Poll select sits in bits 3 to 0, resets 1111, coded periods.
// - Each poll turns current sources on for per-group active-poll times.
`ifndef SWIE_MAP_VH
`define SWIE_MAP_VH
// ==========================================================================
// Register addresses and layout.
`define SWIE_ADDR_SP_EN     7'h0D
`define SWIE_ADDR_SG_EN     7'h0E
`define SWIE_ADDR_LPM       7'h0F
`define SWIE_SP_W           12
`define SWIE_SG_W           21
`define SWIE_LPM_W          8
`define SWIE_SP_RST         12'hFFF
`define SWIE_SG_RST         21'h1FFFFF
`define SWIE_LPM_RST        8'h0F
`define SWIE_WAKE_HI        7
`define SWIE_WAKE_LO        4
`define SWIE_POLL_HI        3
`define SWIE_POLL_LO        0
`define SWIE_WAKE_OFF       4'h0
// ==========================================================================
// Frame layout.
`define SWIE_FRAME_BITS     32
`define SWIE_CNT_W          6
`define SWIE_ADDR_HI        31
`define SWIE_ADDR_LO        25
`define SWIE_RW_BIT         24
`define SWIE_FAULT_BIT      23
`define SWIE_FLAG_BIT       22
`define SWIE_DATA_W         22
// ==========================================================================
// Timing.
`define SWIE_CLK_HZ         20000000
`define SWIE_TICK_MS        1
`define SWIE_MS_W           10
`define SWIE_CYC_W          16
`endif

// ### rtl/swie_top.v
// Interrupt-enable and low-power configuration register bank with SPI access.
`timescale 1ns/10ps
`include "swie_map.vh"

module swie_top #(
   parameter TICK_CYC = `SWIE_CLK_HZ / 1000 * `SWIE_TICK_MS,
   parameter [`SWIE_CYC_W-1:0] SG_POLL_CYC = 16'h0014,
   parameter [`SWIE_CYC_W-1:0] SB_POLL_CYC = 16'h0028
) (
   input  wire                  clk,
   input  wire                  rst,
   input  wire                  spi_sclk,
   input  wire                  spi_cs_b,
   input  wire                  spi_mosi,
   output reg                   spi_miso,
   output wire                  spi_miso_oe,
   input  wire [`SWIE_SP_W-1:0] sp_change,
   input  wire [`SWIE_SG_W-1:0] sg_change,
   input  wire                  fault_present,
   input  wire                  low_power,
   output reg                   int_b,
   output reg                   wake_req,
   output reg                   poll_event,
   output reg                   sg_source_on,
   output reg                   sb_source_on
);

   // ==========================================================================
   // Period tables, in milliseconds.
   function [`SWIE_MS_W-1:0] wake_ms;
      input [3:0] code;
      begin
         case (code)
            4'h1: wake_ms = 10'd6;
            4'h2: wake_ms = 10'd12;
            4'h3: wake_ms = 10'd24;
            4'h4: wake_ms = 10'd48;
            4'h5: wake_ms = 10'd96;
            4'h6: wake_ms = 10'd192;
            4'h7: wake_ms = 10'd394;
            4'h8: wake_ms = 10'd4;
            4'h9: wake_ms = 10'd8;
            4'hA: wake_ms = 10'd16;
            4'hB: wake_ms = 10'd32;
            4'hC: wake_ms = 10'd64;
            4'hD: wake_ms = 10'd128;
            4'hE: wake_ms = 10'd256;
            4'hF: wake_ms = 10'd512;
            default: wake_ms = 10'd0;
         endcase
      end
   endfunction

   function [`SWIE_MS_W-1:0] poll_ms;
      input [3:0] code;
      begin
         case (code)
            4'h0: poll_ms = 10'd3;
            4'h1: poll_ms = 10'd6;
            4'h2: poll_ms = 10'd12;
            4'h3: poll_ms = 10'd24;
            4'h4: poll_ms = 10'd48;
            4'h5: poll_ms = 10'd68;
            4'h6: poll_ms = 10'd76;
            4'h7: poll_ms = 10'd128;
            4'h8: poll_ms = 10'd32;
            4'h9: poll_ms = 10'd36;
            4'hA: poll_ms = 10'd40;
            4'hB: poll_ms = 10'd44;
            4'hC: poll_ms = 10'd52;
            4'hD: poll_ms = 10'd56;
            4'hE: poll_ms = 10'd60;
            default: poll_ms = 10'd64;
         endcase
      end
   endfunction

   // ==========================================================================
   // Pin synchronisers; a level counts once the second and third stages agree.
   reg  [2:0] sync_sclk;
   reg  [2:0] sync_cs;
   reg  [2:0] sync_mosi;
   reg        sclk_q;
   reg        cs_b_q;
   reg        mosi_q;
   reg        sclk_prev;
   reg        cs_prev;

   // Three-stage capture of every SPI pin.
   always @(posedge clk) begin
      if (rst) begin
         sync_sclk <= 3'h0;
         sync_cs   <= 3'h7;
         sync_mosi <= 3'h0;
      end else begin
         sync_sclk <= {sync_sclk[1:0], spi_sclk};
         sync_cs   <= {sync_cs[1:0], spi_cs_b};
         sync_mosi <= {sync_mosi[1:0], spi_mosi};
      end
   end

   // Accepted levels only move when the two late stages agree.
   always @(posedge clk) begin
      if (rst) begin
         sclk_q    <= 1'b0;
         cs_b_q    <= 1'b1;
         mosi_q    <= 1'b0;
         sclk_prev <= 1'b0;
         cs_prev   <= 1'b1;
      end else begin
         if (sync_sclk[1] == sync_sclk[2])
            sclk_q <= sync_sclk[2];
         if (sync_cs[1] == sync_cs[2])
            cs_b_q <= sync_cs[2];
         if (sync_mosi[1] == sync_mosi[2])
            mosi_q <= sync_mosi[2];
         sclk_prev <= sclk_q;
         cs_prev   <= cs_b_q;
      end
   end

   wire sclk_rise  = sclk_q & ~sclk_prev;
   wire sclk_fall  = ~sclk_q & sclk_prev;
   wire frame_end  = cs_b_q & ~cs_prev;
   wire frame_open = ~cs_b_q & cs_prev;

   // ==========================================================================
   // Registers and frame state.
   reg  [`SWIE_SP_W-1:0]         sp_irq_en;
   reg  [`SWIE_SG_W-1:0]         sg_irq_en;
   reg  [`SWIE_LPM_W-1:0]        lpm_cfg;
   reg  [`SWIE_FRAME_BITS-1:0]   rx_shift;
   reg  [`SWIE_FRAME_BITS-1:0]   tx_shift;
   reg  [`SWIE_CNT_W-1:0]        bit_cnt;
   reg  [`SWIE_ADDR_HI-`SWIE_RW_BIT:0] last_cmd;
   reg                           interrupt_event_flag;
   reg  [`SWIE_DATA_W-1:0]       read_data;

   wire [3:0] wake_sel = lpm_cfg[`SWIE_WAKE_HI:`SWIE_WAKE_LO];
   wire [3:0] poll_sel = lpm_cfg[`SWIE_POLL_HI:`SWIE_POLL_LO];
   wire [6:0] rx_addr  = rx_shift[`SWIE_ADDR_HI:`SWIE_ADDR_LO];
   wire       rx_write = rx_shift[`SWIE_RW_BIT];
   wire       frame_ok = frame_end && (bit_cnt == `SWIE_FRAME_BITS);
   wire [6:0] prev_addr = last_cmd[`SWIE_ADDR_HI-`SWIE_RW_BIT:1];

   // Read mux on the previous command's address; unused bits stay zero.
   always @* begin
      read_data = {`SWIE_DATA_W{1'b0}};
      case (prev_addr)
         `SWIE_ADDR_SP_EN: read_data[`SWIE_SP_W-1:0] = sp_irq_en;
         `SWIE_ADDR_SG_EN: read_data[`SWIE_SG_W-1:0] = sg_irq_en;
         `SWIE_ADDR_LPM:   read_data[`SWIE_LPM_W-1:0] = lpm_cfg;
         default:          read_data = {`SWIE_DATA_W{1'b0}};
      endcase
   end

   // Shift engine: MOSI is taken on SCLK rising, MISO moves on SCLK falling.
   // The reply is loaded as CS falls, so flags are the ones live at frame start.
   always @(posedge clk) begin
      if (rst) begin
         rx_shift <= {`SWIE_FRAME_BITS{1'b0}};
         tx_shift <= {`SWIE_FRAME_BITS{1'b0}};
         bit_cnt  <= {`SWIE_CNT_W{1'b0}};
         spi_miso <= 1'b0;
      end else if (frame_open) begin
         tx_shift <= {last_cmd, fault_present, interrupt_event_flag, read_data};
         spi_miso <= last_cmd[`SWIE_ADDR_HI-`SWIE_RW_BIT];
         bit_cnt  <= {`SWIE_CNT_W{1'b0}};
      end else if (!cs_b_q) begin
         if (sclk_rise) begin
            rx_shift <= {rx_shift[`SWIE_FRAME_BITS-2:0], mosi_q};
            if (bit_cnt != `SWIE_FRAME_BITS)
               bit_cnt <= bit_cnt + 6'd1;
         end
         if (sclk_fall) begin
            tx_shift <= {tx_shift[`SWIE_FRAME_BITS-2:0], 1'b0};
            spi_miso <= tx_shift[`SWIE_FRAME_BITS-2];
         end
      end
   end

   assign spi_miso_oe = ~cs_b_q;

   // Register writes and command capture on a complete frame only.
   // A short frame is dropped whole, so a glitched CS cannot corrupt state; a long frame acts on its last 32 bits.
   always @(posedge clk) begin
      if (rst) begin
         sp_irq_en <= `SWIE_SP_RST;
         sg_irq_en <= `SWIE_SG_RST;
         lpm_cfg   <= `SWIE_LPM_RST;
         last_cmd  <= 8'h00;
      end else if (frame_ok) begin
         last_cmd <= rx_shift[`SWIE_ADDR_HI:`SWIE_RW_BIT];
         if (rx_write) begin
            case (rx_addr)
               `SWIE_ADDR_SP_EN: sp_irq_en <= rx_shift[`SWIE_SP_W-1:0];
               `SWIE_ADDR_SG_EN: sg_irq_en <= rx_shift[`SWIE_SG_W-1:0];
               `SWIE_ADDR_LPM:   lpm_cfg   <= rx_shift[`SWIE_LPM_W-1:0];
               default:          lpm_cfg   <= lpm_cfg;
            endcase
         end
      end
   end

   // ==========================================================================
   // Millisecond tick divider.
   reg  [`SWIE_CYC_W-1:0] div_cnt;
   reg                    ms_tick;

   // One-cycle enable every millisecond, counted from entry into low power.
   // A free-running divider would let the first period of every timer run
   // up to one tick short; holding it outside low power keeps each period whole.
   always @(posedge clk) begin
      if (rst) begin
         div_cnt <= {`SWIE_CYC_W{1'b0}};
         ms_tick <= 1'b0;
      end else if (!low_power) begin
         div_cnt <= {`SWIE_CYC_W{1'b0}};
         ms_tick <= 1'b0;
      end else if (div_cnt == TICK_CYC[`SWIE_CYC_W-1:0] - 16'd1) begin
         div_cnt <= {`SWIE_CYC_W{1'b0}};
         ms_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 16'd1;
         ms_tick <= 1'b0;
      end
   end

   // ==========================================================================
   // Wake timer and polling schedule, running only in low power.
   reg  [`SWIE_MS_W-1:0]  wake_cnt;
   reg  [`SWIE_MS_W-1:0]  poll_cnt;
   reg  [`SWIE_CYC_W-1:0] sg_cnt;
   reg  [`SWIE_CYC_W-1:0] sb_cnt;

   wire wake_hit = low_power && (wake_sel != `SWIE_WAKE_OFF) && ms_tick &&
                   (wake_cnt >= wake_ms(wake_sel) - 10'd1);
   wire poll_hit = low_power && ms_tick &&
                   (poll_cnt >= poll_ms(poll_sel) - 10'd1);

   // Counters restart on entry to low power; >= catches a period shortened mid-count.
   always @(posedge clk) begin
      if (rst) begin
         wake_cnt   <= {`SWIE_MS_W{1'b0}};
         poll_cnt   <= {`SWIE_MS_W{1'b0}};
         wake_req   <= 1'b0;
         poll_event <= 1'b0;
      end else begin
         wake_req   <= wake_hit;
         poll_event <= poll_hit;
         if (!low_power || wake_sel == `SWIE_WAKE_OFF || wake_hit)
            wake_cnt <= {`SWIE_MS_W{1'b0}};
         else if (ms_tick)
            wake_cnt <= wake_cnt + 10'd1;
         if (!low_power || poll_hit)
            poll_cnt <= {`SWIE_MS_W{1'b0}};
         else if (ms_tick)
            poll_cnt <= poll_cnt + 10'd1;
      end
   end

   // Source-on windows after each poll, timed per channel group.
   always @(posedge clk) begin
      if (rst) begin
         sg_cnt       <= {`SWIE_CYC_W{1'b0}};
         sb_cnt       <= {`SWIE_CYC_W{1'b0}};
         sg_source_on <= 1'b0;
         sb_source_on <= 1'b0;
      end else if (poll_event) begin
         sg_cnt       <= SG_POLL_CYC;
         sb_cnt       <= SB_POLL_CYC;
         sg_source_on <= 1'b1;
         sb_source_on <= 1'b1;
      end else begin
         if (sg_cnt != 16'd0)
            sg_cnt <= sg_cnt - 16'd1;
         if (sb_cnt != 16'd0)
            sb_cnt <= sb_cnt - 16'd1;
         sg_source_on <= (sg_cnt > 16'd1);
         sb_source_on <= (sb_cnt > 16'd1);
      end
   end

   // ==========================================================================
   // Interrupt-event flag and interrupt pin.
   wire enabled_change = |(sp_change & sp_irq_en) | |(sg_change & sg_irq_en);
   wire irq_set        = enabled_change | wake_hit;

   // A completed frame clears the flag it just reported; a new event wins.
   always @(posedge clk) begin
      if (rst) begin
         interrupt_event_flag <= 1'b0;
         int_b                <= 1'b1;
      end else begin
         if (irq_set)
            interrupt_event_flag <= 1'b1;
         else if (frame_ok)
            interrupt_event_flag <= 1'b0;
         int_b <= ~(irq_set | (interrupt_event_flag & ~frame_ok));
      end
   end

endmodule // swie_top

// ### tb/swie_top_properties.sv
// Checker for the switch enable and low-power register bank ports.
`timescale 1ns/10ps
`include "swie_map.vh"
module swie_top_properties #(
   parameter                   TICK_CYC    = 20,
   parameter [`SWIE_CYC_W-1:0] SG_POLL_CYC = 16'h0014,
   parameter [`SWIE_CYC_W-1:0] SB_POLL_CYC = 16'h0028
) (
   input wire                  clk,
   input wire                  rst,
   input wire                  spi_sclk,
   input wire                  spi_cs_b,
   input wire                  spi_mosi,
   input wire                  spi_miso,
   input wire                  spi_miso_oe,
   input wire [`SWIE_SP_W-1:0] sp_change,
   input wire [`SWIE_SG_W-1:0] sg_change,
   input wire                  fault_present,
   input wire                  low_power,
   input wire                  int_b,
   input wire                  wake_req,
   input wire                  poll_event,
   input wire                  sg_source_on,
   input wire                  sb_source_on
);
   // ======================================
   // Window length counters.
   reg [`SWIE_CYC_W-1:0] sg_run;
   reg [`SWIE_CYC_W-1:0] sb_run;
   // A repetition cannot hold these lengths, so the clocks are counted here.
   always @(posedge clk) begin
      sg_run <= (rst || !sg_source_on) ? 16'h0000 : sg_run + 16'h0001;
      sb_run <= (rst || !sb_source_on) ? 16'h0000 : sb_run + 16'h0001;
   end
   // ======================================
   // Properties.
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_opens;
      ##[2:6] spi_miso_oe;
   endsequence
   sequence s_closes;
      ##[2:6] !spi_miso_oe;
   endsequence
   a_oe_open: assert property ($fell(spi_cs_b) |-> s_opens)
      else $error("reply enable late");
   a_oe_close: assert property ($rose(spi_cs_b) |-> s_closes)
      else $error("reply enable stuck");
   a_int_cause: assert property ($fell(int_b) |-> $past(|sp_change || |sg_change) || wake_req)
      else $error("interrupt without cause");
   a_wake_int: assert property (wake_req |-> ##[0:1] !int_b)
      else $error("wake without interrupt");
   a_wake_lp: assert property (wake_req |-> $past(low_power))
      else $error("wake outside low power");
   a_poll_pulse: assert property (poll_event |=> !poll_event)
      else $error("poll pulse too long");
   a_lp_idle: assert property (!$past(low_power) && !$past(low_power, 2) |-> !poll_event && !wake_req)
      else $error("timer event while awake");
   a_sg_window: assert property ($fell(sg_source_on) && low_power |-> sg_run == SG_POLL_CYC)
      else $error("ground source window length");
   a_sb_window: assert property ($fell(sb_source_on) && low_power |-> sb_run == SB_POLL_CYC)
      else $error("battery source window length");
endmodule // swie_top_properties

// ### tb/swie_host.sv
// Host model that runs serial frames against the register bank.
`timescale 1ns/10ps
module swie_host (
   output reg  spi_sclk,
   output reg  spi_cs_b,
   output reg  spi_mosi,
   input  wire spi_miso,
   input  wire spi_miso_oe
);
   // The link idles with its clock parked and select released.
   initial begin
      spi_sclk = 1'b0;
      spi_cs_b = 1'b1;
      spi_mosi = 1'b0;
   end
   // One frame of n bits, first bit first; reply sampled late in each high phase.
   task xfer(input [31:0] tx, input integer n, output [31:0] rx);
      integer i;
      begin
         rx = 32'h00000000;
         #13 spi_cs_b = 1'b0;
         #400;
         for (i = 31; i > 31 - n; i = i - 1) begin
            spi_mosi = tx[i];
            #200 spi_sclk = 1'b1;
            #190 rx[i] = spi_miso & spi_miso_oe;
            #10 spi_sclk = 1'b0;
         end
         #400 spi_cs_b = 1'b1;
         spi_mosi = ~spi_mosi; // Released data line no longer holds its last bit.
         #400;
      end
   endtask
endmodule // swie_host

// ### tb/swie_top_tb.sv
// Self-checking testbench for the switch enable and low-power register bank.
`timescale 1ns/10ps
`include "swie_map.vh"
module swie_top_tb;
   localparam TK = 20;
   reg                  clk = 1'b0;
   reg                  rst = 1'b1;
   reg [`SWIE_SP_W-1:0] sp_change = 12'h000;
   reg [`SWIE_SG_W-1:0] sg_change = 21'h00000;
   reg                  fault_present = 1'b0;
   reg                  low_power = 1'b0;
   reg [31:0]           rx;
   wire                 spi_sclk, spi_cs_b, spi_mosi, spi_miso, spi_miso_oe;
   wire                 int_b, wake_req, poll_event, sg_source_on, sb_source_on;
   integer              fails = 0, num_checks = 0, c, n, tw, tp, tp2, lim;
   integer wms [0:15] = '{0, 6, 12, 24, 48, 96, 192, 394, 4, 8, 16, 32, 64, 128, 256, 512};
   integer pms [0:15] = '{3, 6, 12, 24, 48, 68, 76, 128, 32, 36, 40, 44, 52, 56, 60, 64};
   swie_top #(.TICK_CYC(TK)) i_swie_top (.clk(clk), .rst(rst), .spi_sclk(spi_sclk),
      .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .sp_change(sp_change), .sg_change(sg_change),
      .fault_present(fault_present), .low_power(low_power), .int_b(int_b),
      .wake_req(wake_req), .poll_event(poll_event), .sg_source_on(sg_source_on),
      .sb_source_on(sb_source_on));
   swie_host i_swie_host (.spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
   // ======================================
   // Clock, checks and frame helpers.
   always #25 clk = ~clk;
   task chk(input [31:0] got, input [31:0] want);
      begin
         num_checks = num_checks + 1;
         if (got !== want) begin
            fails = fails + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
         end
      end
   endtask
   // Timer figures may land a few clocks late through the tick pipeline.
   task near(input integer got, input integer want);
      chk((got >= want && got <= want + 4) ? want : got, want);
   endtask
   task acc(input [6:0] a, input w, input [23:0] d);
      i_swie_host.xfer({a, w, d}, 32, rx);
   endtask
   task pulse(input [11:0] sp, input [20:0] sg);
      begin
         @(posedge clk);
         sp_change <= sp;
         sg_change <= sg;
         @(posedge clk);
         sp_change <= 12'h000;
         sg_change <= 21'h00000;
         @(negedge clk);
      end
   endtask
   task close_out;
      begin
         if (fails == 0 && num_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   // A hang past 5 ms, just under twice the expected run, ends it as a failure.
   initial begin
      #5000000;
      fails = fails + 1;
      close_out;
   end
   // ======================================
   // Test sequence.
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk({int_b, spi_miso_oe, wake_req, poll_event}, 32'h8);
      acc(7'h0D, 1'b0, 24'h0);
      acc(7'h0E, 1'b0, 24'h0);
      chk(rx, 32'h1A000FFF);
      acc(7'h0F, 1'b0, 24'h0);
      chk(rx, 32'h1C1FFFFF);
      acc(7'h11, 1'b0, 24'h0);
      chk(rx, 32'h1E00000F);
      acc(7'h0D, 1'b1, 24'hFFFFFE);
      chk(rx, 32'h22000000);
      acc(7'h0E, 1'b1, 24'hFFFFFF);
      chk(rx, 32'h1B000FFE);
      pulse(12'h001, 21'h00000);
      chk({31'h0, int_b}, 32'h1);
      pulse(12'h000, 21'h100000);
      chk({31'h0, int_b}, 32'h0);
      @(posedge clk);
      fault_present <= 1'b1;
      acc(7'h0E, 1'b0, 24'h0);
      chk(rx, 32'h1DDFFFFF);
      @(posedge clk);
      fault_present <= 1'b0;
      acc(7'h0F, 1'b0, 24'h0);
      chk(rx, 32'h1C1FFFFF);
      chk({31'h0, int_b}, 32'h1);
      i_swie_host.xfer({7'h0D, 1'b1, 24'h0}, 16, rx);
      acc(7'h0D, 1'b0, 24'h0);
      chk(rx, 32'h1E00000F);
      acc(7'h0F, 1'b0, 24'h0);
      chk(rx, 32'h1A000FFE);
      // Every wake and poll code in turn; wake timed from entry into low power, polls by their spacing.
      for (c = 0; c < 16; c = c + 1) begin
         acc(7'h0F, 1'b1, {16'h0000, c[3:0], c[3:0]});
         lim = ((wms[c] > 2 * pms[c]) ? wms[c] : 2 * pms[c]) * TK + 10;
         tw = 0;
         tp = 0;
         tp2 = 0;
         @(posedge clk);
         low_power <= 1'b1;
         for (n = 1; n <= lim; n = n + 1) begin
            @(negedge clk);
            if (wake_req === 1'b1 && tw == 0)
               tw = n;
            if (poll_event === 1'b1 && tp != 0 && tp2 == 0)
               tp2 = n;
            if (poll_event === 1'b1 && tp == 0)
               tp = n;
         end
         near(tw, wms[c] * TK);
         near(tp2 - tp, pms[c] * TK);
         chk({31'h0, int_b}, (wms[c] == 0) ? 32'h1 : 32'h0);
         @(posedge clk);
         low_power <= 1'b0;
      end
      close_out;
   end
endmodule // swie_top_tb
bind swie_top swie_top_properties #(.TICK_CYC(TICK_CYC), .SG_POLL_CYC(SG_POLL_CYC),
   .SB_POLL_CYC(SB_POLL_CYC)) i_swie_top_properties (.clk(clk), .rst(rst),
   .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
   .spi_miso_oe(spi_miso_oe), .sp_change(sp_change), .sg_change(sg_change),
   .fault_present(fault_present), .low_power(low_power), .int_b(int_b),
   .wake_req(wake_req), .poll_event(poll_event), .sg_source_on(sg_source_on),
   .sb_source_on(sb_source_on));
